// file: hdl/tstw_pkg.sv
`default_nettype none
package tstw_pkg;
  // Clock and timing
  localparam int          CLK_HZ         = 250_000_000;
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          TIMEOUT_MS     = 30;
  localparam int          TIMEOUT_CYC    = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int          TIMEOUT_W      = 24;
  localparam int          SPIKE_FS_NS    = 16;
  localparam int          SPIKE_HS_NS    = 4;
  localparam int          FILT_FS_CYC    = (SPIKE_FS_NS / CLK_PERIOD_NS < 1) ? 1 :
                                           SPIKE_FS_NS / CLK_PERIOD_NS;
  localparam int          FILT_HS_CYC    = (SPIKE_HS_NS / CLK_PERIOD_NS < 1) ? 1 :
                                           SPIKE_HS_NS / CLK_PERIOD_NS;
  localparam int          FILT_W         = 4;

  // Bus codes
  localparam logic [6:0]  GC_ADDR        = 7'h00;
  localparam logic [7:0]  GC_RESET_CMD   = 8'h06;
  localparam logic [4:0]  HS_CODE_TOP    = 5'h01;
  localparam logic [3:0]  BYTE_BITS      = 4'h8;
  localparam logic [2:0]  TX_LAST_BIT    = 3'h7;

  // Pointer map
  localparam logic [7:0]  PTR_LOCAL      = 8'h00;
  localparam logic [7:0]  PTR_REMOTE     = 8'h01;
  localparam logic [7:0]  PTR_CFG1       = 8'h09;
  localparam logic [7:0]  PTR_SOFT_RESET = 8'hFC;
  localparam logic [7:0]  PTR_MFR_ID     = 8'hFE;
  localparam logic [7:0]  PTR_DEV_ID     = 8'hFF;

  // Fields and power-on values
  localparam int          PD_BIT         = 6;
  localparam int          FAULT_BIT      = 0;
  localparam logic [7:0]  CFG1_POR       = 8'h00;
  localparam logic [7:0]  PTR_POR        = 8'h00;
  localparam logic [15:0] RES_POR        = 16'h0000;
  localparam logic [15:0] SHORT_RESULT   = 16'hC000;

  typedef enum logic [2:0] {
    TSTW_IDLE  = 3'b000,
    TSTW_RX    = 3'b001,
    TSTW_ACK   = 3'b010,
    TSTW_TX    = 3'b011,
    TSTW_TXACK = 3'b100
  } tstw_state_e;

  typedef enum logic [1:0] {
    TSTW_K_ADDR = 2'b00,
    TSTW_K_PTR  = 2'b01,
    TSTW_K_DATA = 2'b10,
    TSTW_K_GC   = 2'b11
  } tstw_kind_e;

  typedef enum logic {
    TSTW_SEQ_IDLE = 1'b0,
    TSTW_SEQ_CONV = 1'b1
  } tstw_seq_e;
endpackage
`default_nettype wire

// file: hdl/tstw_line_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tstw_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic hs;

  modport front (output scl, sda, scl_rise, scl_fall, start, stop, input hs);
  modport core  (input scl, sda, scl_rise, scl_fall, start, stop, output hs);
endinterface
`default_nettype wire

// file: hdl/tstw_line_front.sv
`timescale 1ns/1ps
`default_nettype none
module tstw_line_front #(
  parameter int FILT_FS = tstw_pkg::FILT_FS_CYC,
  parameter int FILT_HS = tstw_pkg::FILT_HS_CYC
) (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  tstw_line_if.front  lines
);
  import tstw_pkg::*;

  generate
    if (FILT_FS < 1 || FILT_HS < 1 || FILT_FS >= 2**FILT_W || FILT_HS >= 2**FILT_W) begin : g_chk
      $error("tstw_line_front: filter length out of range");
    end
  endgenerate

  typedef struct packed {
    logic [1:0]        scl_sync;
    logic [1:0]        sda_sync;
    logic [FILT_W-1:0] scl_cnt;
    logic [FILT_W-1:0] sda_cnt;
    logic              scl_f;
    logic              sda_f;
    logic              rise;
    logic              fall;
    logic              start;
    logic              stop;
  } tstw_front_s;

  tstw_front_s s_ff;
  tstw_front_s nxt_s;
  logic [FILT_W-1:0] lim;

  // Spike filter: level accepted after lim stable cycles
  function automatic logic [FILT_W:0] filt_step(input logic raw, input logic lvl,
                                                input logic [FILT_W-1:0] cnt,
                                                input logic [FILT_W-1:0] limit);
    if (raw == lvl) begin
      filt_step = {lvl, {FILT_W{1'b0}}};
    end else if (cnt + 1'b1 >= limit) begin
      filt_step = {raw, {FILT_W{1'b0}}};
    end else begin
      filt_step = {lvl, cnt + 1'b1};
    end
  endfunction

  assign lim = lines.hs ? FILT_HS[FILT_W-1:0] : FILT_FS[FILT_W-1:0]; // R12

  // Synchronise, filter, find edges and bus conditions
  always_comb begin
    nxt_s          = s_ff;
    nxt_s.scl_sync = {s_ff.scl_sync[0], scl_in};
    nxt_s.sda_sync = {s_ff.sda_sync[0], sda_in};
    {nxt_s.scl_f, nxt_s.scl_cnt} = filt_step(s_ff.scl_sync[1], s_ff.scl_f, s_ff.scl_cnt, lim);
    {nxt_s.sda_f, nxt_s.sda_cnt} = filt_step(s_ff.sda_sync[1], s_ff.sda_f, s_ff.sda_cnt, lim);
    nxt_s.rise  = ~s_ff.scl_f & nxt_s.scl_f;
    nxt_s.fall  = s_ff.scl_f & ~nxt_s.scl_f;
    nxt_s.start = s_ff.scl_f & nxt_s.scl_f & s_ff.sda_f & ~nxt_s.sda_f;  // R8
    nxt_s.stop  = s_ff.scl_f & nxt_s.scl_f & ~s_ff.sda_f & nxt_s.sda_f;  // R8
  end

  // State register, lines idle high
  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_cnt: '0, sda_cnt: '0,
                scl_f: 1'b1, sda_f: 1'b1, rise: 1'b0, fall: 1'b0,
                start: 1'b0, stop: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lines.scl      = s_ff.scl_f;
  assign lines.sda      = s_ff.sda_f;
  assign lines.scl_rise = s_ff.rise;
  assign lines.scl_fall = s_ff.fall;
  assign lines.start    = s_ff.start;
  assign lines.stop     = s_ff.stop;
endmodule // tstw_line_front
`default_nettype wire

// file: hdl/tstw_target.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: First byte after a write address loads the register pointer.
// R2: Controller sends a pointer byte first in every write.
// R3: Reads return the pointed register; pointer holds until the next write.
// R4: Controller changes read register by pointer-only write then repeated START.
// R5: Two-byte registers go out high byte first, then low byte.
// R6: Controller ends a single-byte read with not-acknowledge.
// R7: Controller acknowledges first byte, not-acknowledges second in two-byte reads.
// R8: START is data falling with clock high; STOP is data rising.
// R9: Controller sets byte count and ends with repeated START or STOP.
// R10: Receiver holds data low through the ninth clock high phase.
// R11: Controller sends high-speed master code first to exceed 400kHz.
// R12: Master code 0000 1xxx gets no acknowledge; filters switch to high speed.
// R13: High-speed mode holds until STOP, then filters return to fast mode.
// R14: Line low 30ms inside a frame resets interface and releases data.
// R15: Controller keeps clock at or above 1kHz during transfers.
// R16: Power-down bit 6 of config one stops conversions after the current one.
// R17: With power-down clear, conversions follow each other continuously.
// R18: Fault comparator trip during conversion sets remote result bit 0.
// R19: Host ignores remaining result bits when the fault flag is set.
// R20: Shorted remote input reports minus 64 degrees.
// R21: Address byte is seven address bits then direction, one means read.
// R22: General call acknowledged; second byte 06h resets registers, aborts conversion.
// R23: Any write at pointer FCh resets registers and aborts conversion.
// R24: Pointers FEh and FFh read fixed maker and device codes.
// R25: Acknowledge only a matching address, else stay released until START.
// R26: Acknowledge every written byte, pointer and data alike.
module tstw_target #(
  parameter int         TIMEOUT_CYCLES = tstw_pkg::TIMEOUT_CYC,
  parameter logic [7:0] MFR_CODE       = 8'hA5,  // Arbitrary value
  parameter logic [7:0] DEV_CODE       = 8'h3C   // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic [6:0]  target_addr,
  output logic             conv_start,
  input  wire logic        conv_done,
  input  wire logic        remote_fault_cmp,
  input  wire logic        remote_short,
  input  wire logic [15:0] local_adc,
  input  wire logic [15:0] remote_adc,
  output logic             power_down_bit,
  output logic             analog_enable,
  output logic             high_speed_bus_mode
);
  import tstw_pkg::*;

  generate
    if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES >= 2**TIMEOUT_W) begin : g_chk
      $error("tstw_target: TIMEOUT_CYCLES out of range");
    end
  endgenerate

  typedef struct packed {
    tstw_state_e          st;
    tstw_kind_e           kind;
    logic [3:0]           cnt;
    logic [7:0]           shreg;
    logic [7:0]           tx;
    logic                 rw;
    logic                 byte_idx;
    logic [7:0]           ptr;
    logic [7:0]           cfg1;
    logic [15:0]          local_res;
    logic [15:0]          remote_res;
    tstw_seq_e            seq;
    logic                 fault_seen;
    logic                 conv_start;
    logic                 hs;
    logic                 frame;
    logic [TIMEOUT_W-1:0] to_cnt;
  } tstw_core_s;

  localparam logic [TIMEOUT_W-1:0] TO_LAST = TIMEOUT_W'(TIMEOUT_CYCLES - 1);

  tstw_core_s   s_ff;
  tstw_core_s   nxt_s;
  tstw_line_if  lines ();

  tstw_line_front u_front (
    .clk    (clk),
    .rst    (rst),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .lines  (lines)
  );

  // Byte presented for a read at pointer and byte index
  function automatic logic [7:0] rd_byte(input logic [7:0] ptr, input logic idx,
                                         input tstw_core_s s);
    logic [15:0] w;
    w = 16'h0000;
    case (ptr)
      PTR_LOCAL:  w = s.local_res;
      PTR_REMOTE: w = s.remote_res;
      default:    w = 16'h0000;
    endcase
    case (ptr)
      PTR_LOCAL,
      PTR_REMOTE: rd_byte = idx ? w[7:0] : w[15:8];  // R5
      PTR_CFG1:   rd_byte = s.cfg1;
      PTR_MFR_ID: rd_byte = MFR_CODE;                 // R24
      PTR_DEV_ID: rd_byte = DEV_CODE;                 // R24
      default:    rd_byte = 8'h00;
    endcase
  endfunction

  // Bus engine, timeout and conversion sequencer
  always_comb begin
    logic srst;
    logic [7:0] b;
    srst             = 1'b0;
    b                = s_ff.shreg;
    nxt_s            = s_ff;
    nxt_s.conv_start = 1'b0;

    // Stuck-line timeout inside a frame
    if (s_ff.frame && (!lines.scl || !lines.sda)) begin
      nxt_s.to_cnt = s_ff.to_cnt + 1'b1;
    end else begin
      nxt_s.to_cnt = '0;
    end

    case (s_ff.st)
      TSTW_RX: begin
        if (lines.scl_rise) begin
          nxt_s.shreg = {s_ff.shreg[6:0], lines.sda};
          nxt_s.cnt   = s_ff.cnt + 1'b1;
        end else if (lines.scl_fall && s_ff.cnt == BYTE_BITS) begin
          nxt_s.cnt = 4'h0;
          nxt_s.st  = TSTW_ACK;                                  // R10 R26
          case (s_ff.kind)
            TSTW_K_ADDR: begin
              nxt_s.rw = b[0];                                   // R21
              if (b[7:1] == GC_ADDR && !b[0]) begin
                nxt_s.kind = TSTW_K_GC;                          // R22
              end else if (b[7:3] == HS_CODE_TOP) begin
                nxt_s.hs = 1'b1;                                 // R12
                nxt_s.st = TSTW_IDLE;                            // R12
              end else if (b[7:1] == target_addr) begin
                nxt_s.kind = TSTW_K_PTR;                         // R25
              end else begin
                nxt_s.st = TSTW_IDLE;                            // R25
              end
            end
            TSTW_K_PTR: begin
              nxt_s.ptr  = b;                                    // R1
              nxt_s.kind = TSTW_K_DATA;
            end
            TSTW_K_DATA: begin
              if (s_ff.ptr == PTR_CFG1) begin
                nxt_s.cfg1 = b;
              end
              srst = (s_ff.ptr == PTR_SOFT_RESET);               // R23
            end
            default: begin
              srst = (b == GC_RESET_CMD);                        // R22
            end
          endcase
        end
      end
      TSTW_ACK: begin
        if (lines.scl_fall) begin
          if (s_ff.rw && s_ff.kind == TSTW_K_PTR) begin
            nxt_s.st       = TSTW_TX;
            nxt_s.byte_idx = 1'b0;
            nxt_s.tx       = rd_byte(s_ff.ptr, 1'b0, s_ff);      // R3
          end else begin
            nxt_s.st = TSTW_RX;
          end
        end
      end
      TSTW_TX: begin
        if (lines.scl_fall) begin
          if (s_ff.cnt[2:0] == TX_LAST_BIT) begin
            nxt_s.cnt = 4'h0;
            nxt_s.st  = TSTW_TXACK;
          end else begin
            nxt_s.tx  = {s_ff.tx[6:0], 1'b0};
            nxt_s.cnt = s_ff.cnt + 1'b1;
          end
        end
      end
      TSTW_TXACK: begin
        if (lines.scl_rise) begin
          nxt_s.shreg[0] = lines.sda;
        end else if (lines.scl_fall) begin
          if (!s_ff.shreg[0]) begin
            nxt_s.st       = TSTW_TX;
            nxt_s.byte_idx = ~s_ff.byte_idx;
            nxt_s.tx       = rd_byte(s_ff.ptr, ~s_ff.byte_idx, s_ff); // R5
          end else begin
            nxt_s.st = TSTW_IDLE;
          end
        end
      end
      default: begin
        nxt_s.st = TSTW_IDLE;
      end
    endcase

    // Bus conditions override the engine
    if (lines.start) begin
      nxt_s.st    = TSTW_RX;                                     // R8
      nxt_s.kind  = TSTW_K_ADDR;
      nxt_s.cnt   = 4'h0;
      nxt_s.frame = 1'b1;
    end
    if (lines.stop) begin
      nxt_s.st    = TSTW_IDLE;                                   // R8
      nxt_s.hs    = 1'b0;                                        // R13
      nxt_s.frame = 1'b0;
    end
    if (s_ff.to_cnt == TO_LAST) begin
      nxt_s.st     = TSTW_IDLE;                                  // R14
      nxt_s.frame  = 1'b0;
      nxt_s.to_cnt = '0;
    end

    // Conversion sequencer
    case (s_ff.seq)
      TSTW_SEQ_IDLE: begin
        if (!s_ff.cfg1[PD_BIT]) begin
          nxt_s.conv_start = 1'b1;                               // R17
          nxt_s.fault_seen = 1'b0;
          nxt_s.seq        = TSTW_SEQ_CONV;
        end
      end
      TSTW_SEQ_CONV: begin
        nxt_s.fault_seen = s_ff.fault_seen | remote_fault_cmp;   // R18
        if (conv_done) begin
          nxt_s.seq       = TSTW_SEQ_IDLE;                       // R16
          nxt_s.local_res = local_adc;
          if (remote_short) begin
            nxt_s.remote_res = SHORT_RESULT;                     // R20
          end else begin
            nxt_s.remote_res = remote_adc;
            nxt_s.remote_res[FAULT_BIT] = s_ff.fault_seen | remote_fault_cmp; // R18
          end
        end
      end
      default: begin
        nxt_s.seq = TSTW_SEQ_IDLE;
      end
    endcase

    // Software reset restores registers and aborts conversion
    if (srst) begin
      nxt_s.ptr        = PTR_POR;                                // R22 R23
      nxt_s.cfg1       = CFG1_POR;
      nxt_s.local_res  = RES_POR;
      nxt_s.remote_res = RES_POR;
      nxt_s.seq        = TSTW_SEQ_IDLE;
      nxt_s.conv_start = 1'b0;
      nxt_s.fault_seen = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '{st: TSTW_IDLE, kind: TSTW_K_ADDR, cnt: 4'h0, shreg: 8'h00,
                tx: 8'h00, rw: 1'b0, byte_idx: 1'b0, ptr: PTR_POR,
                cfg1: CFG1_POR, local_res: RES_POR, remote_res: RES_POR,
                seq: TSTW_SEQ_IDLE, fault_seen: 1'b0, conv_start: 1'b0,
                hs: 1'b0, frame: 1'b0, to_cnt: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Open-drain drive: ack slot or a zero data bit
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~((s_ff.st == TSTW_ACK) ||
                      (s_ff.st == TSTW_TX && !s_ff.tx[7]));      // R10 R14

  assign lines.hs            = s_ff.hs;
  assign high_speed_bus_mode = s_ff.hs;
  assign conv_start          = s_ff.conv_start;
  assign power_down_bit      = s_ff.cfg1[PD_BIT];
  assign analog_enable       = (s_ff.seq == TSTW_SEQ_CONV) || !s_ff.cfg1[PD_BIT]; // R16
endmodule // tstw_target
`default_nettype wire

// file: verification/tstw_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tstw_checker #(
  parameter int TIMEOUT_CYCLES = tstw_pkg::TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_n,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic power_down_bit,
  input wire logic analog_enable,
  input wire logic high_speed_bus_mode
);
  int low_cnt_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Consecutive cycles with the bus clock pin low
  always_ff @(posedge clk) begin
    if (rst || scl_in) low_cnt_ff <= 0;
    else if (low_cnt_ff < TIMEOUT_CYCLES + 64) low_cnt_ff <= low_cnt_ff + 1;
  end
  // Data line held low, or left free, for eight clock cycles
  sequence s_held; !sda_oe_n [*8]; endsequence
  sequence s_free; sda_oe_n [*8]; endsequence
  sequence s_done_run; conv_done && !power_down_bit ##1 !power_down_bit; endsequence
  property p_reset_state;
    disable iff (1'h0) $fell(rst) |-> sda_oe_n && !power_down_bit && !high_speed_bus_mode;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("state after reset");
  property p_hold; $fell(sda_oe_n) |-> s_held; endproperty
  a_hold: assert property (p_hold) else $error("drive too short");
  property p_still; $changed(sda_oe_n) |-> !scl_in; endproperty
  a_still: assert property (p_still) else $error("data moved with clock high");
  property p_code_nack; $rose(high_speed_bus_mode) |-> s_free; endproperty
  a_code_nack: assert property (p_code_nack) else $error("master code driven");
  property p_hs_stop; $fell(high_speed_bus_mode) |-> scl_in && sda_in; endproperty
  a_hs_stop: assert property (p_hs_stop) else $error("fast mode without stop");
  property p_timeout; low_cnt_ff == TIMEOUT_CYCLES + 32 |-> sda_oe_n; endproperty
  a_timeout: assert property (p_timeout) else $error("line not released");
  property p_pulse; conv_start |=> !conv_start; endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
  property p_restart; s_done_run |-> ##[0:3] conv_start; endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_pd_stop; conv_done && power_down_bit |-> ##[1:2] !analog_enable; endproperty
  a_pd_stop: assert property (p_pd_stop) else $error("analog still on");
  property p_pd_idle; power_down_bit && !analog_enable |-> !conv_start; endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("start while down");
endmodule // tstw_checker
`default_nettype wire

// file: verification/tstw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tstw_host_model #(
  parameter int Q_NS = 24
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  // Lines released, pulled up on the wire
  initial begin
    scl_low = 1'h0;
    sda_low = 1'h0;
  end
  // One clock pulse: data set while low, sampled mid high
  task automatic bit_io(input logic b, output logic rb);
    sda_low = !b;
    #(Q_NS);
    scl_low = 1'h0;
    #(Q_NS);
    rb = sda;
    #(Q_NS);
    scl_low = 1'h1;
    #(Q_NS);
  endtask
  // Start or repeated start: data falls with clock high
  task automatic start_bit;
    sda_low = 1'h0;
    #(Q_NS);
    scl_low = 1'h0;
    #(Q_NS);
    sda_low = 1'h1;
    #(Q_NS);
    scl_low = 1'h1;
    #(Q_NS);
  endtask
  // Stop: data rises with clock high
  task automatic stop_bit;
    sda_low = 1'h1;
    #(Q_NS);
    scl_low = 1'h0;
    #(Q_NS);
    sda_low = 1'h0;
    #(2 * Q_NS);
  endtask
  // Byte most significant bit first, then acknowledge slot
  task automatic byte_io(input logic [7:0] w, input logic a, output logic [7:0] rv,
                         output logic g);
    for (int i = 7; i >= 0; i--) bit_io(w[i], rv[i]);
    bit_io(a, g);
  endtask
endmodule // tstw_host_model
`default_nettype wire

// file: verification/tstw_target_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tstw_target_bench;
  import tstw_pkg::*;
  localparam int          TOC  = 2000;
  localparam logic [6:0]  ADDR = 7'h2A;
  localparam logic [7:0]  MFR  = 8'h5A;  // Arbitrary value
  localparam logic [7:0]  DEV  = 8'h7E;  // Arbitrary value
  localparam logic [15:0] LOC  = 16'h1A50;
  localparam logic [15:0] REM  = 16'h2B60;
  logic        clk, rst, conv_done, fault_cmp, short_in, h_scl, h_sda, sda_out, sda_oe_n;
  logic        conv_start, power_down_bit, analog_enable, high_speed_bus_mode, g;
  logic [7:0]  r;
  logic [15:0] v;
  logic [5:0]  cnt;
  int          fails, total_checks;
  logic [23:0] rows [6];
  wire logic   scl, sda;
  // Wired-and bus with pull-ups
  assign scl = !h_scl;
  assign sda = !h_sda && (sda_oe_n ? 1'h1 : sda_out);
  tstw_target #(.TIMEOUT_CYCLES(TOC), .MFR_CODE(MFR), .DEV_CODE(DEV)) i_tstw_target (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .target_addr(ADDR), .conv_start(conv_start), .conv_done(conv_done),
    .remote_fault_cmp(fault_cmp), .remote_short(short_in), .local_adc(LOC),
    .remote_adc(REM), .power_down_bit(power_down_bit), .analog_enable(analog_enable),
    .high_speed_bus_mode(high_speed_bus_mode));
  tstw_host_model i_tstw_host_model (.scl(scl), .sda(sda), .scl_low(h_scl), .sda_low(h_sda));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // Converter stand-in: result ready 30 cycles after a start
  always @(negedge clk) begin
    conv_done <= (cnt == 6'h01);
    if (conv_start) cnt <= 6'h1E;
    else if (cnt != 6'h00) cnt <= cnt - 6'h01;
  end
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %0t bit %b not %b", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %0t byte %h not %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic waitn(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Address with write direction and pointer, frame left open
  task automatic wrp(input logic [7:0] p);
    i_tstw_host_model.start_bit();
    i_tstw_host_model.byte_io({ADDR, 1'h0}, 1'h1, r, g);
    chk_bit(g, 1'h0);
    i_tstw_host_model.byte_io(p, 1'h1, r, g);
    chk_bit(g, 1'h0);
  endtask
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
    wrp(p);
    i_tstw_host_model.byte_io(d, 1'h1, r, g);
    chk_bit(g, 1'h0);
    i_tstw_host_model.stop_bit();
  endtask
  // Two-byte read: acknowledge first, refuse second
  task automatic rd;
    i_tstw_host_model.start_bit();
    i_tstw_host_model.byte_io({ADDR, 1'h1}, 1'h1, r, g);
    chk_bit(g, 1'h0);
    i_tstw_host_model.byte_io(8'hFF, 1'h0, v[15:8], g);
    i_tstw_host_model.byte_io(8'hFF, 1'h1, v[7:0], g);
    i_tstw_host_model.stop_bit();
  endtask
  task automatic gc(input logic [7:0] c);
    i_tstw_host_model.start_bit();
    i_tstw_host_model.byte_io(8'h00, 1'h1, r, g);
    chk_bit(g, 1'h0);
    i_tstw_host_model.byte_io(c, 1'h1, r, g);
    chk_bit(g, 1'h0);
    i_tstw_host_model.stop_bit();
  endtask
  // Watchdog
  initial begin
    #200000;
    fails++;
    $display("unexpected %0t watchdog", $time);
    complete_run();
  end
  initial begin
    rst = 1'h1;
    fault_cmp = 1'h0;
    short_in = 1'h0;
    cnt = 6'h00;
    conv_done = 1'h0;
    rows = '{{PTR_LOCAL, LOC}, {PTR_REMOTE, REM}, {PTR_CFG1, 16'h0000}, {PTR_MFR_ID, MFR, MFR},
             {PTR_DEV_ID, DEV, DEV}, {8'h05, 16'h0000}};
    waitn(12);
    rst = 1'h0;
    waitn(100);
    chk_bit(sda_oe_n, 1'h1);
    chk_bit(high_speed_bus_mode, 1'h0);
    // Ordinary reads, one row each
    foreach (rows[i]) begin
      wrp(rows[i][23:16]);
      rd();
      chk_byte(v[15:8], rows[i][15:8]);
      chk_byte(v[7:0], rows[i][7:0]);
    end
    // Foreign address left alone
    i_tstw_host_model.start_bit();
    i_tstw_host_model.byte_io({ADDR ^ 7'h01, 1'h0}, 1'h1, r, g);
    chk_bit(g, 1'h1);
    i_tstw_host_model.stop_bit();
    // Power down, pointer kept, general call and soft reset
    wr_reg(PTR_CFG1, 8'h40);
    waitn(80);
    chk_bit(power_down_bit, 1'h1);
    chk_bit(analog_enable, 1'h0);
    rd();
    chk_byte(v[15:8], 8'h40);
    rd();
    chk_byte(v[7:0], 8'h40);
    gc(8'h07);
    chk_bit(power_down_bit, 1'h1);
    gc(8'h06);
    waitn(4);
    chk_bit(power_down_bit, 1'h0);
    wr_reg(PTR_CFG1, 8'h40);
    wr_reg(PTR_SOFT_RESET, 8'hA5);
    waitn(80);
    chk_bit(power_down_bit, 1'h0);
    rd();
    chk_byte(v[15:8], LOC[15:8]);
    // Fault flag, then shorted input
    fault_cmp = 1'h1;
    waitn(80);
    wrp(PTR_REMOTE);
    rd();
    chk_bit(v[0], 1'h1);
    fault_cmp = 1'h0;
    short_in = 1'h1;
    waitn(80);
    wrp(PTR_REMOTE);
    rd();
    chk_byte(v[15:8], 8'hC0);
    short_in = 1'h0;
    // Every master code, a transfer, then back to fast mode
    for (int c = 8; c < 16; c++) begin
      i_tstw_host_model.start_bit();
      i_tstw_host_model.byte_io(c[7:0], 1'h1, r, g);
      chk_bit(g, 1'h1);
      waitn(20);
      chk_bit(high_speed_bus_mode, 1'h1);
      wrp(PTR_MFR_ID);
      rd();
      chk_byte(v[15:8], MFR);
      waitn(20);
      chk_bit(high_speed_bus_mode, 1'h0);
    end
    // Clock held low while the device drives a zero
    i_tstw_host_model.start_bit();
    i_tstw_host_model.byte_io({ADDR, 1'h1}, 1'h1, r, g);
    waitn(20);
    chk_bit(sda_oe_n, 1'h0);
    waitn(TOC + 100);
    chk_bit(sda_oe_n, 1'h1);
    i_tstw_host_model.stop_bit();
    wrp(PTR_DEV_ID);
    rd();
    chk_byte(v[15:8], DEV);
    complete_run();
  end
endmodule // tstw_target_bench
bind tstw_target tstw_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_tstw_checker (
  .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
  .conv_start(conv_start), .conv_done(conv_done), .power_down_bit(power_down_bit),
  .analog_enable(analog_enable), .high_speed_bus_mode(high_speed_bus_mode));
`default_nettype wire
